//--- rtl/scc_defines.vh
// register map, field positions, mode codes and timing constants of the serial channel
`ifndef SCC_DEFINES_VH
`define SCC_DEFINES_VH

`define SCC_ADDR_W 8
`define SCC_OFF_DATA 8'h04
`define SCC_OFF_CTRL 8'h08
`define SCC_OFF_MODE 8'h0c

`define SCC_SEL_NONE 3'b000
`define SCC_SEL_DATA 3'b001
`define SCC_SEL_CTRL 3'b010
`define SCC_SEL_MODE 3'b100

`define SCC_B_RX_NINTH 7
`define SCC_B_EVEN 6
`define SCC_B_PAR_EN 5
`define SCC_B_OVERRUN 4
`define SCC_B_PAR_UND 3
`define SCC_B_FRAMING 2
`define SCC_B_EDGE_SEL 1
`define SCC_B_CLK_SRC 0

`define SCC_B_TX_NINTH 7
`define SCC_MODE_HI 3
`define SCC_MODE_LO 2

`define SCC_MODE_SYNC 2'b00
`define SCC_MODE_U7 2'b01
`define SCC_MODE_U8 2'b10
`define SCC_MODE_U9 2'b11

`define SCC_RESP_OKAY 2'b00
`define SCC_RESP_SLVERR 2'b10

`define SCC_BAUD_DIV 16'h0364
`define SCC_SYNC_LAST 4'h7
`define SCC_RESET_WORD 32'h0000_0000

`endif

//--- rtl/scc_engine.v
// serial engine: uart transmit/receive and clocked synchronous shifter
//
// Added by the designer: the AXI4-Lite interface to the registers and the register offsets.
`include "scc_defines.vh"

module scc_engine #(
   parameter [15:0] BAUD_DIV = `SCC_BAUD_DIV
) (
   // clock and reset
   input wire ref_clk_i,
   input wire reset_i,
   // configuration
   input wire [1:0] transfer_mode_field_i,
   input wire even_i,
   input wire parity_add_enable_i,
   input wire shift_edge_select_i,
   input wire sync_clock_source_i,
   // transmit request
   input wire tx_req_i,
   input wire [8:0] tx_word_i,
   output reg tx_ack_o,
   // pins
   input wire serial_in_pin_i,
   input wire shift_clock_pin_i,
   output reg serial_out_pin_o,
   output reg shift_clock_pin_o,
   output reg shift_clock_oe_n_o,
   // receive results and error events
   output reg rx_done_o,
   output reg [8:0] rx_word_o,
   output reg parity_err_o,
   output reg framing_err_o,
   output reg underrun_o
);
   localparam R_IDLE = 2'b01;
   localparam R_UART = 2'b10;

   function [3:0] data_bits;
      input [1:0] m;
      begin
         case (m)
            `SCC_MODE_U7: data_bits = 4'h7;
            `SCC_MODE_U9: data_bits = 4'h9;
            default: data_bits = 4'h8;
         endcase
      end
   endfunction

   // parity bit over the first n bits; odd parity inverts the plain xor
   function parity_of;
      input [8:0] w;
      input [3:0] n;
      input ev;
      integer i;
      begin
         parity_of = ~ev;
         for (i = 0; i < 9; i = i + 1) begin
            if (i < n) parity_of = parity_of ^ w[i];
         end
      end
   endfunction

   function [8:0] mask_word;
      input [9:0] w;
      input [3:0] n;
      integer i;
      begin
         mask_word = 9'h000;
         for (i = 0; i < 9; i = i + 1) begin
            if (i < n) mask_word[i] = w[i];
         end
      end
   endfunction

   wire uart = transfer_mode_field_i != `SCC_MODE_SYNC;
   wire [3:0] nd = data_bits(transfer_mode_field_i);
   // parity exists only in the 7 and 8 bit uart modes
   wire par_on = parity_add_enable_i &
      (transfer_mode_field_i == `SCC_MODE_U7 || transfer_mode_field_i == `SCC_MODE_U8);
   wire [3:0] np = {3'h0, par_on};

   reg [15:0] bcnt;
   wire tick = bcnt == 16'h0000;
   reg [11:0] tsr;
   reg [3:0] tcnt;
   reg tbusy;
   reg [1:0] rstate;
   reg [15:0] rph;
   reg [3:0] ridx;
   reg [9:0] rfr;
   reg rxd_prev;
   reg sclk_gen;
   reg clk_prev;
   reg src_prev;
   reg [3:0] scnt;
   reg [7:0] ssr;

   reg [11:0] frame;
   integer k;
   always @* begin
      frame = 12'hfff;
      frame[0] = 1'b0;
      for (k = 0; k < 9; k = k + 1) begin
         if (k < nd) frame[k + 1] = tx_word_i[k];
      end
      if (par_on) frame[nd + 4'h1] = parity_of(tx_word_i, nd, even_i);
   end

   // internal clock only when the shift clock comes from the divider
   wire lvl = sync_clock_source_i ? shift_clock_pin_i : sclk_gen;
   // a source switch is not a clock edge
   wire src_same = src_prev == sync_clock_source_i;
   wire rise = src_same & ~clk_prev & lvl;
   wire fall = src_same & clk_prev & ~lvl;
   wire lead = shift_edge_select_i ? rise : fall;
   wire trail = shift_edge_select_i ? fall : rise;
   wire sync_act = ~uart;
   wire [3:0] stop_idx = nd + np + 4'h1;

   always @(posedge ref_clk_i or posedge reset_i) begin
      if (reset_i) begin
         bcnt <= 16'h0000;
         tsr <= 12'hfff;
         tcnt <= 4'h0;
         tbusy <= 1'b0;
         tx_ack_o <= 1'b0;
         serial_out_pin_o <= 1'b1;
         shift_clock_pin_o <= 1'b1;
         shift_clock_oe_n_o <= 1'b1;
         sclk_gen <= 1'b1;
         clk_prev <= 1'b1;
         src_prev <= 1'b0;
         scnt <= 4'h0;
         ssr <= 8'h00;
         rstate <= R_IDLE;
         rph <= 16'h0000;
         ridx <= 4'h0;
         rfr <= 10'h000;
         rxd_prev <= 1'b1;
         rx_done_o <= 1'b0;
         rx_word_o <= 9'h000;
         parity_err_o <= 1'b0;
         framing_err_o <= 1'b0;
         underrun_o <= 1'b0;
      end else begin
         bcnt <= tick ? BAUD_DIV - 16'h0001 : bcnt - 16'h0001;
         tx_ack_o <= 1'b0;
         rx_done_o <= 1'b0;
         parity_err_o <= 1'b0;
         framing_err_o <= 1'b0;
         underrun_o <= 1'b0;
         rxd_prev <= serial_in_pin_i;
         clk_prev <= lvl;
         src_prev <= sync_clock_source_i;
         shift_clock_pin_o <= sclk_gen;
         shift_clock_oe_n_o <= ~(sync_act & ~sync_clock_source_i);
         // transmit side
         if (tx_req_i & ~tbusy) begin
            tbusy <= 1'b1;
            tx_ack_o <= 1'b1;
            if (uart) begin
               tsr <= frame;
               tcnt <= stop_idx + 4'h1;
            end else begin
               tsr <= {4'hf, tx_word_i[7:0]};
            end
         end else if (uart & tbusy & tick) begin
            if (tcnt != 4'h0) begin
               serial_out_pin_o <= tsr[0];
               tsr <= {1'b1, tsr[11:1]};
               tcnt <= tcnt - 4'h1;
            end else begin
               tbusy <= 1'b0;
            end
         end else if (sync_act & lead & tbusy) begin
            serial_out_pin_o <= tsr[0];
            tsr <= {1'b1, tsr[11:1]};
         end
         // external clock asking for a bit with nothing loaded
         if (sync_act & sync_clock_source_i & lead & ~tbusy & scnt == 4'h0) begin
            underrun_o <= 1'b1;
         end
         // idle level is high for edge select 0 and low for edge select 1
         if (sync_act & ~sync_clock_source_i & tbusy) begin
            if (tick) sclk_gen <= ~sclk_gen;
         end else begin
            sclk_gen <= ~shift_edge_select_i;
         end
         // synchronous receive, eight bits lsb first
         if (sync_act & trail) begin
            ssr <= {serial_in_pin_i, ssr[7:1]};
            if (scnt == `SCC_SYNC_LAST) begin
               scnt <= 4'h0;
               tbusy <= 1'b0;
               rx_done_o <= 1'b1;
               rx_word_o <= {1'b0, serial_in_pin_i, ssr[7:1]};
            end else begin
               scnt <= scnt + 4'h1;
            end
         end else if (uart) begin
            scnt <= 4'h0;
         end
         // uart receive, sampled mid bit
         case (rstate)
            R_IDLE: begin
               if (uart & rxd_prev & ~serial_in_pin_i) begin
                  rstate <= R_UART;
                  rph <= {1'b0, BAUD_DIV[15:1]};
                  ridx <= 4'h0;
               end
            end
            R_UART: begin
               if (rph != 16'h0000) begin
                  rph <= rph - 16'h0001;
               end else begin
                  rph <= BAUD_DIV - 16'h0001;
                  ridx <= ridx + 4'h1;
                  if (ridx == 4'h0) begin
                     if (serial_in_pin_i) rstate <= R_IDLE; // start glitch
                  end else if (ridx == stop_idx) begin
                     rstate <= R_IDLE;
                     rx_done_o <= 1'b1;
                     rx_word_o <= mask_word(rfr, nd);
                     parity_err_o <= par_on & (rfr[nd] != parity_of(rfr[8:0], nd, even_i));
                     framing_err_o <= ~serial_in_pin_i;
                  end else begin
                     rfr[ridx - 4'h1] <= serial_in_pin_i;
                  end
               end
            end
            default: rstate <= R_IDLE;
         endcase
      end
   end
endmodule // scc_engine

//--- rtl/scc_top.v
// serial channel control/status register with axi4-lite slave and serial engine
//
// Function
// - in 9-bit uart mode the ninth received bit of the last character reads in the control register.
// - parity is odd when the polarity bit is 0 and even when it is 1.
// - a parity bit is sent and checked only while the parity enable bit is 1.
// - a read-only overrun flag goes to 1 when an overrun occurs.
// - a read-only flag goes to 1 on a parity error or a transmit underrun.
// - a read-only framing flag goes to 1 when a received frame is malformed.
// - with edge select 0 in sync mode, bits leave on falling and enter on rising edges; idle high.
// - with edge select 1 in sync mode, bits leave on rising and enter on falling edges; idle low.
// - in sync mode the shift clock comes from the divider at source 0 and the pin at source 1.
// - the mode field selects 00 sync, 01 7-bit, 10 8-bit, 11 9-bit uart.
`include "scc_defines.vh"

module scc_top #(
   parameter [15:0] BAUD_DIV = `SCC_BAUD_DIV
) (
   // clock and reset
   input wire ref_clk_i,
   input wire reset_i,
   // axi4-lite write address and data
   input wire s_axi_awvalid_i,
   output reg s_axi_awready_o,
   input wire [`SCC_ADDR_W-1:0] s_axi_awaddr_i,
   input wire s_axi_wvalid_i,
   output reg s_axi_wready_o,
   input wire [31:0] s_axi_wdata_i,
   input wire [3:0] s_axi_wstrb_i,
   // axi4-lite write response
   output reg s_axi_bvalid_o,
   input wire s_axi_bready_i,
   output reg [1:0] s_axi_bresp_o,
   // axi4-lite read
   input wire s_axi_arvalid_i,
   output reg s_axi_arready_o,
   input wire [`SCC_ADDR_W-1:0] s_axi_araddr_i,
   output reg s_axi_rvalid_o,
   input wire s_axi_rready_i,
   output reg [31:0] s_axi_rdata_o,
   output reg [1:0] s_axi_rresp_o,
   // serial pins
   input wire serial_in_pin_i,
   input wire shift_clock_pin_i,
   output wire serial_out_pin_o,
   output wire shift_clock_pin_o,
   output wire shift_clock_oe_n_o
);
   function [2:0] reg_sel;
      input [`SCC_ADDR_W-1:0] a;
      begin
         case (a)
            `SCC_OFF_DATA: reg_sel = `SCC_SEL_DATA;
            `SCC_OFF_CTRL: reg_sel = `SCC_SEL_CTRL;
            `SCC_OFF_MODE: reg_sel = `SCC_SEL_MODE;
            default: reg_sel = `SCC_SEL_NONE;
         endcase
      end
   endfunction

   // control fields
   reg even;
   reg parity_add_enable;
   reg shift_edge_select;
   reg sync_clock_source;
   reg [1:0] transfer_mode_field;
   reg tx_ninth_bit;
   // status
   reg overrun_flag;
   reg parity_underrun_flag;
   reg framing_flag;
   reg [8:0] rx_word;
   reg rx_full;
   reg [7:0] tx_data;
   reg tx_pend;
   // bus holding state
   reg aw_ok;
   reg w_ok;
   reg [`SCC_ADDR_W-1:0] aw_addr;
   reg [31:0] w_data;
   reg [3:0] w_strb;

   wire tx_ack;
   wire rx_done;
   wire [8:0] rx_word_new;
   wire parity_err;
   wire framing_err;
   wire underrun;

   wire do_write = aw_ok & w_ok & ~s_axi_bvalid_o;
   wire [2:0] wsel = reg_sel(aw_addr);
   wire wr_lane0 = do_write & w_strb[0];
   wire do_read = s_axi_arvalid_i & s_axi_arready_o;
   wire [2:0] rsel = reg_sel(s_axi_araddr_i);
   wire rd_ctrl = do_read & rsel == `SCC_SEL_CTRL;
   wire rd_data = do_read & rsel == `SCC_SEL_DATA;
   wire rx_ninth_bit = rx_word[8];

   reg [31:0] rd_mux;
   always @* begin
      rd_mux = `SCC_RESET_WORD;
      case (rsel)
         `SCC_SEL_DATA: rd_mux[8:0] = rx_word;
         `SCC_SEL_CTRL: begin
            rd_mux[`SCC_B_RX_NINTH] = rx_ninth_bit;
            rd_mux[`SCC_B_EVEN] = even;
            rd_mux[`SCC_B_PAR_EN] = parity_add_enable;
            rd_mux[`SCC_B_OVERRUN] = overrun_flag;
            rd_mux[`SCC_B_PAR_UND] = parity_underrun_flag;
            rd_mux[`SCC_B_FRAMING] = framing_flag;
            rd_mux[`SCC_B_EDGE_SEL] = shift_edge_select;
            rd_mux[`SCC_B_CLK_SRC] = sync_clock_source;
         end
         `SCC_SEL_MODE: begin
            rd_mux[`SCC_B_TX_NINTH] = tx_ninth_bit;
            rd_mux[`SCC_MODE_HI:`SCC_MODE_LO] = transfer_mode_field;
         end
         default: rd_mux = `SCC_RESET_WORD;
      endcase
   end

   // axi4-lite slave
   always @(posedge ref_clk_i or posedge reset_i) begin
      if (reset_i) begin
         s_axi_awready_o <= 1'b0;
         s_axi_wready_o <= 1'b0;
         s_axi_bvalid_o <= 1'b0;
         s_axi_bresp_o <= `SCC_RESP_OKAY;
         s_axi_arready_o <= 1'b0;
         s_axi_rvalid_o <= 1'b0;
         s_axi_rdata_o <= `SCC_RESET_WORD;
         s_axi_rresp_o <= `SCC_RESP_OKAY;
         aw_ok <= 1'b0;
         w_ok <= 1'b0;
         aw_addr <= {`SCC_ADDR_W{1'b0}};
         w_data <= `SCC_RESET_WORD;
         w_strb <= 4'h0;
      end else begin
         if (s_axi_awvalid_i & s_axi_awready_o) begin
            s_axi_awready_o <= 1'b0;
            aw_ok <= 1'b1;
            aw_addr <= s_axi_awaddr_i;
         end else if (~aw_ok & ~s_axi_bvalid_o) begin
            s_axi_awready_o <= 1'b1;
         end
         if (s_axi_wvalid_i & s_axi_wready_o) begin
            s_axi_wready_o <= 1'b0;
            w_ok <= 1'b1;
            w_data <= s_axi_wdata_i;
            w_strb <= s_axi_wstrb_i;
         end else if (~w_ok & ~s_axi_bvalid_o) begin
            s_axi_wready_o <= 1'b1;
         end
         if (do_write) begin
            aw_ok <= 1'b0;
            w_ok <= 1'b0;
            s_axi_bvalid_o <= 1'b1;
            s_axi_bresp_o <= wsel == `SCC_SEL_NONE ? `SCC_RESP_SLVERR : `SCC_RESP_OKAY;
         end else if (s_axi_bvalid_o & s_axi_bready_i) begin
            s_axi_bvalid_o <= 1'b0;
         end
         if (do_read) begin
            s_axi_arready_o <= 1'b0;
            s_axi_rvalid_o <= 1'b1;
            s_axi_rdata_o <= rd_mux;
            s_axi_rresp_o <= rsel == `SCC_SEL_NONE ? `SCC_RESP_SLVERR : `SCC_RESP_OKAY;
         end else if (s_axi_rvalid_o & s_axi_rready_i) begin
            s_axi_rvalid_o <= 1'b0;
         end else if (~s_axi_rvalid_o & ~s_axi_arready_o) begin
            s_axi_arready_o <= 1'b1;
         end
      end
   end

   // registers; a new event in the cycle of a clearing read wins
   always @(posedge ref_clk_i or posedge reset_i) begin
      if (reset_i) begin
         even <= 1'b0;
         parity_add_enable <= 1'b0;
         shift_edge_select <= 1'b0;
         sync_clock_source <= 1'b0;
         transfer_mode_field <= `SCC_MODE_SYNC;
         tx_ninth_bit <= 1'b0;
         overrun_flag <= 1'b0;
         parity_underrun_flag <= 1'b0;
         framing_flag <= 1'b0;
         rx_word <= 9'h000;
         rx_full <= 1'b0;
         tx_data <= 8'h00;
         tx_pend <= 1'b0;
      end else begin
         if (wr_lane0 & wsel == `SCC_SEL_CTRL) begin
            even <= w_data[`SCC_B_EVEN];
            parity_add_enable <= w_data[`SCC_B_PAR_EN];
            shift_edge_select <= w_data[`SCC_B_EDGE_SEL];
            sync_clock_source <= w_data[`SCC_B_CLK_SRC];
         end
         if (wr_lane0 & wsel == `SCC_SEL_MODE) begin
            transfer_mode_field <= w_data[`SCC_MODE_HI:`SCC_MODE_LO];
            tx_ninth_bit <= w_data[`SCC_B_TX_NINTH];
         end
         if (wr_lane0 & wsel == `SCC_SEL_DATA) begin
            tx_data <= w_data[7:0];
         end
         tx_pend <= (wr_lane0 & wsel == `SCC_SEL_DATA) | (tx_pend & ~tx_ack);
         if (rx_done) rx_word <= rx_word_new;
         rx_full <= rx_done | (rx_full & ~rd_data);
         overrun_flag <= (rx_done & rx_full) | (overrun_flag & ~rd_ctrl);
         parity_underrun_flag <= parity_err | underrun |
            (parity_underrun_flag & ~rd_ctrl);
         framing_flag <= framing_err | (framing_flag & ~rd_ctrl);
      end
   end

   scc_engine #(
      .BAUD_DIV(BAUD_DIV)
   ) u_engine (
      .ref_clk_i(ref_clk_i),
      .reset_i(reset_i),
      .transfer_mode_field_i(transfer_mode_field),
      .even_i(even),
      .parity_add_enable_i(parity_add_enable),
      .shift_edge_select_i(shift_edge_select),
      .sync_clock_source_i(sync_clock_source),
      .tx_req_i(tx_pend),
      .tx_word_i({tx_ninth_bit, tx_data}),
      .tx_ack_o(tx_ack),
      .serial_in_pin_i(serial_in_pin_i),
      .shift_clock_pin_i(shift_clock_pin_i),
      .serial_out_pin_o(serial_out_pin_o),
      .shift_clock_pin_o(shift_clock_pin_o),
      .shift_clock_oe_n_o(shift_clock_oe_n_o),
      .rx_done_o(rx_done),
      .rx_word_o(rx_word_new),
      .parity_err_o(parity_err),
      .framing_err_o(framing_err),
      .underrun_o(underrun)
   );
endmodule // scc_top

//--- test/scc_top_sva.sv
// bus and shift clock checker bound to the serial channel top
module scc_top_sva #(
   parameter [15:0] BAUD_DIV = 16'h0364
) (
   // clock and reset
   input wire ref_clk_i,
   input wire reset_i,
   // write channels
   input wire s_axi_awvalid_i,
   input wire s_axi_awready_o,
   input wire [7:0] s_axi_awaddr_i,
   input wire s_axi_wvalid_i,
   input wire s_axi_wready_o,
   input wire [31:0] s_axi_wdata_i,
   input wire s_axi_bvalid_o,
   input wire s_axi_bready_i,
   input wire [1:0] s_axi_bresp_o,
   // read channels
   input wire s_axi_arvalid_i,
   input wire s_axi_arready_o,
   input wire [7:0] s_axi_araddr_i,
   input wire s_axi_rvalid_o,
   input wire s_axi_rready_i,
   input wire [31:0] s_axi_rdata_o,
   input wire [1:0] s_axi_rresp_o,
   // shift clock pin
   input wire shift_clock_pin_o,
   input wire shift_clock_oe_n_o
);
   timeunit 1ns;
   timeprecision 1ns;
   localparam int LOWMAX = BAUD_DIV + 2;
   reg pend;
   reg [7:0] wa;
   reg [7:0] wd;
   reg [7:0] c;
   reg [1:0] md;
   reg [1:0] stab;
   wire drv = md == 2'h0 && !c[0];
   // shadow assumes address and data arrive together, as the bench sends them
   always @(posedge ref_clk_i or posedge reset_i) begin
      if (reset_i) begin
         pend <= 1'b0;
         wa <= 8'h00;
         wd <= 8'h00;
         c <= 8'h00;
         md <= 2'h0;
         stab <= 2'h0;
      end else begin
         pend <= s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o;
         wa <= s_axi_awaddr_i;
         wd <= s_axi_wdata_i[7:0];
         if (pend && wa == 8'h08) c <= wd & 8'h63;
         if (pend && wa == 8'h0c) md <= wd[3:2];
         if (pend) stab <= 2'h0;
         else if (stab != 2'h3) stab <= stab + 2'h1;
      end
   end
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (reset_i);
   sequence s_wtake;
      s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o;
   endsequence
   sequence s_rtake;
      s_axi_arvalid_i && s_axi_arready_o;
   endsequence
   AST_B_AFTER_W: assert property (s_wtake |-> ##2 s_axi_bvalid_o)
      else $error("write response late");
   AST_B_HOLD: assert property (s_axi_bvalid_o && !s_axi_bready_i
      |=> s_axi_bvalid_o && $stable(s_axi_bresp_o)) else $error("write response dropped");
   AST_R_AFTER_AR: assert property (s_rtake |=> s_axi_rvalid_o)
      else $error("read data late");
   AST_R_HOLD: assert property (s_axi_rvalid_o && !s_axi_rready_i
      |=> s_axi_rvalid_o && $stable(s_axi_rdata_o)) else $error("read data dropped");
   AST_UNMAPPED: assert property (s_rtake ##0 !(s_axi_araddr_i inside {8'h04, 8'h08, 8'h0c})
      |=> s_axi_rresp_o == 2'h2 && s_axi_rdata_o == 32'h0) else $error("unmapped read");
   AST_RD_HIGH: assert property (s_axi_rvalid_o |-> s_axi_rdata_o[31:9] == 23'h0)
      else $error("upper read bits set");
   AST_CTRL_RB: assert property (s_rtake ##0 s_axi_araddr_i == 8'h08
      |=> (s_axi_rdata_o[7:0] & 8'h63) == c) else $error("control readback wrong");
   AST_MODE_RB: assert property (s_rtake ##0 s_axi_araddr_i == 8'h0c
      |=> s_axi_rdata_o[3:2] == md) else $error("mode readback wrong");
   AST_OE_SRC: assert property (stab == 2'h3 |-> shift_clock_oe_n_o == !drv)
      else $error("shift clock enable wrong");
   AST_SCK_LOW: assert property (stab == 2'h3 && drv && !c[1] && $fell(shift_clock_pin_o)
      |-> ##[1:LOWMAX] $rose(shift_clock_pin_o)) else $error("shift clock stuck low");
endmodule // scc_top_sva

bind scc_top scc_top_sva #(.BAUD_DIV(BAUD_DIV)) scc_top_sva_i (
   .ref_clk_i(ref_clk_i), .reset_i(reset_i),
   .s_axi_awvalid_i(s_axi_awvalid_i), .s_axi_awready_o(s_axi_awready_o),
   .s_axi_awaddr_i(s_axi_awaddr_i), .s_axi_wvalid_i(s_axi_wvalid_i),
   .s_axi_wready_o(s_axi_wready_o), .s_axi_wdata_i(s_axi_wdata_i),
   .s_axi_bvalid_o(s_axi_bvalid_o), .s_axi_bready_i(s_axi_bready_i),
   .s_axi_bresp_o(s_axi_bresp_o), .s_axi_arvalid_i(s_axi_arvalid_i),
   .s_axi_arready_o(s_axi_arready_o), .s_axi_araddr_i(s_axi_araddr_i),
   .s_axi_rvalid_o(s_axi_rvalid_o), .s_axi_rready_i(s_axi_rready_i),
   .s_axi_rdata_o(s_axi_rdata_o), .s_axi_rresp_o(s_axi_rresp_o),
   .shift_clock_pin_o(shift_clock_pin_o), .shift_clock_oe_n_o(shift_clock_oe_n_o)
);

//--- test/scc_partner.sv
// remote serial device model: uart line and shift clock partner
module scc_partner #(
   parameter int BD = 8
) (
   // clock and pins seen from the far side
   input wire logic clk_i,
   input wire logic line_i,
   input wire logic clk_pin_i,
   output logic line_o,
   output logic clk_pin_o
);
   timeunit 1ns;
   timeprecision 1ns;
   // line idles high; own clock stands low outside frames
   initial begin
      line_o = 1'b1;
      clk_pin_o = 1'b0;
   end
   task automatic uart_send(input logic [11:0] f, input int n);
      @(posedge clk_i);
      for (int i = 0; i < n; i++) begin
         line_o <= f[i];
         repeat (BD) @(posedge clk_i);
      end
      line_o <= 1'b1;
   endtask
   task automatic uart_get(output logic [11:0] f, input int n);
      f = 12'hfff;
      @(negedge line_i);
      repeat (BD / 2) @(posedge clk_i);
      for (int i = 0; i < n; i++) begin
         f[i] = line_i;
         repeat (BD) @(posedge clk_i);
      end
   endtask
   task automatic sync_get(output logic [7:0] b);
      for (int i = 0; i < 8; i++) begin
         @(posedge clk_pin_i);
         b[i] = line_i;
      end
   endtask
   // data changes on the rising edge and holds through the falling one
   task automatic sync_put(input logic [7:0] b);
      for (int i = 0; i < 8; i++) begin
         @(posedge clk_i);
         clk_pin_o <= 1'b1;
         line_o <= b[i];
         repeat (BD) @(posedge clk_i);
         clk_pin_o <= 1'b0;
         repeat (BD) @(posedge clk_i);
      end
      line_o <= 1'b1;
   endtask
endmodule // scc_partner

//--- test/serial_channel_control_status_test.sv
// self-checking bench: register access, uart frames and shift clock traffic
module serial_channel_control_status_test;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int BD = 8;
   // mode, parity enable, even, ninth bit; parity only in 7 and 8 bit modes
   localparam logic [4:0] cfg [4] = '{5'h0c, 5'h16, 5'h10, 5'h19};
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic awv = 1'b0;
   logic wv = 1'b0;
   logic br = 1'b0;
   logic arv = 1'b0;
   logic rr = 1'b0;
   logic [7:0] awa = 8'h00;
   logic [7:0] ara = 8'h00;
   logic [31:0] wd = 32'h0;
   wire awr, wrdy, bv, arr, rv, sout, sck, oen, sin, scki;
   wire [1:0] bresp, rresp;
   wire [31:0] rdata;
   int n_errors = 0;
   int comparisons = 0;
   scc_top #(.BAUD_DIV(16'h0008)) scc_top_i (
      .ref_clk_i(clk), .reset_i(rst), .s_axi_awvalid_i(awv), .s_axi_awready_o(awr),
      .s_axi_awaddr_i(awa), .s_axi_wvalid_i(wv), .s_axi_wready_o(wrdy), .s_axi_wdata_i(wd),
      .s_axi_wstrb_i(4'hf), .s_axi_bvalid_o(bv), .s_axi_bready_i(br), .s_axi_bresp_o(bresp),
      .s_axi_arvalid_i(arv), .s_axi_arready_o(arr), .s_axi_araddr_i(ara),
      .s_axi_rvalid_o(rv), .s_axi_rready_i(rr), .s_axi_rdata_o(rdata),
      .s_axi_rresp_o(rresp), .serial_in_pin_i(sin), .shift_clock_pin_i(scki),
      .serial_out_pin_o(sout), .shift_clock_pin_o(sck), .shift_clock_oe_n_o(oen));
   scc_partner #(.BD(BD)) scc_partner_i (
      .clk_i(clk), .line_i(sout), .clk_pin_i(sck), .line_o(sin), .clk_pin_o(scki));
   initial begin
      forever #5 clk = ~clk;
   end
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      comparisons++;
      if (g !== e) begin
         n_errors++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      logic ta, tw, tb;
      tb = 1'b0;
      @(posedge clk);
      awv <= 1'b1;
      wv <= 1'b1;
      awa <= a;
      wd <= d;
      br <= 1'b1;
      while (!tb) begin
         @(negedge clk);
         ta = awv && awr;
         tw = wv && wrdy;
         tb = bv;
         r = bresp;
         @(posedge clk);
         if (ta) awv <= 1'b0;
         if (tw) wv <= 1'b0;
      end
      br <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      logic ta, tr;
      tr = 1'b0;
      @(posedge clk);
      arv <= 1'b1;
      ara <= a;
      rr <= 1'b1;
      while (!tr) begin
         @(negedge clk);
         ta = arv && arr;
         tr = rv;
         d = rdata;
         r = rresp;
         @(posedge clk);
         if (ta) arv <= 1'b0;
      end
      rr <= 1'b0;
   endtask
   task automatic rdc(input logic [7:0] a, input logic [31:0] e);
      logic [31:0] d;
      logic [1:0] r;
      rd(a, d, r);
      chk($sformatf("reg %h", a), e, d);
   endtask
   task automatic wro(input logic [7:0] a, input logic [31:0] d);
      logic [1:0] r;
      wr(a, d, r);
      chk("bresp", 32'h0, {30'h0, r});
   endtask
   task automatic rx(input logic [11:0] f);
      scc_partner_i.uart_send(f, 11);
      repeat (2 * BD) @(posedge clk);
   endtask
   function automatic logic [11:0] frm(input logic [8:0] d, input int n, input logic pe,
                                       input logic ev, input logic sb);
      logic [8:0] m;
      m = d & ((9'h001 << n) - 9'h001);
      frm = 12'hffe;
      for (int i = 0; i < n; i++) frm[1 + i] = m[i];
      if (pe) frm[n + 1] = ev ? ^m : ~^m;
      frm[n + 1 + pe] = sb;
   endfunction
   task automatic give_verdict;
      $display("comparisons %0d n_errors %0d", comparisons, n_errors);
      if (n_errors == 0 && comparisons > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge clk);
      n_errors++;
      give_verdict();
   end
   initial begin
      logic [11:0] f;
      logic [7:0] b;
      logic [31:0] d;
      logic [1:0] r;
      logic [4:0] c;
      logic pe;
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      rdc(8'h08, 32'h0);
      rdc(8'h0c, 32'h0);
      wro(8'h08, 32'hffff_ffff);
      rdc(8'h08, 32'h63);
      wr(8'h10, 32'h1, r);
      chk("unmapped bresp", 32'h2, {30'h0, r});
      rd(8'h10, d, r);
      chk("unmapped rresp", 32'h2, {30'h0, r});
      for (int k = 0; k < 4; k++) begin
         c = cfg[k];
         pe = c[2] && c[4:3] != 2'h3;
         wro(8'h08, {25'h0, c[1], c[2], 5'h0});
         wro(8'h0c, {24'h0, c[0], 3'h0, c[4:3], 2'h0});
         fork
            scc_partner_i.uart_get(f, 8 + c[4:3] + pe);
            wro(8'h04, 32'ha5);
         join
         chk("tx frame", frm({c[0], 8'ha5}, 6 + c[4:3], pe, c[1], 1'h1), f);
      end
      wro(8'h0c, 32'h08);
      wro(8'h08, 32'h20);
      rx(frm(9'h03c, 8, 1'h1, 1'h0, 1'h1));
      rdc(8'h04, 32'h3c);
      rdc(8'h08, 32'h20);
      rx(frm(9'h03c, 8, 1'h1, 1'h1, 1'h1));
      rd(8'h04, d, r);
      rdc(8'h08, 32'h28);
      rdc(8'h08, 32'h20);
      rx(frm(9'h03c, 8, 1'h1, 1'h0, 1'h0));
      rd(8'h04, d, r);
      rdc(8'h08, 32'h24);
      rx(frm(9'h011, 8, 1'h1, 1'h0, 1'h1));
      rx(frm(9'h022, 8, 1'h1, 1'h0, 1'h1));
      rdc(8'h08, 32'h30);
      rdc(8'h04, 32'h22);
      wro(8'h0c, 32'h0c);
      wro(8'h08, 32'h0);
      rx(frm(9'h1a5, 9, 1'h0, 1'h0, 1'h1));
      rdc(8'h04, 32'h1a5);
      rdc(8'h08, 32'h80);
      wro(8'h0c, 32'h0);
      wro(8'h08, 32'h0);
      repeat (4) @(posedge clk);
      chk("oe_n", 32'h0, {31'h0, oen});
      chk("clock idle", 32'h1, {31'h0, sck});
      fork
         scc_partner_i.sync_get(b);
         wro(8'h04, 32'hc3);
      join
      chk("sync out", 32'hc3, {24'h0, b});
      repeat (3 * BD) @(posedge clk);
      chk("clock idle", 32'h1, {31'h0, sck});
      rdc(8'h04, 32'hff);
      rdc(8'h08, 32'h0);
      wro(8'h08, 32'h3);
      repeat (4) @(posedge clk);
      chk("oe_n", 32'h1, {31'h0, oen});
      scc_partner_i.sync_put(8'h96);
      repeat (4) @(posedge clk);
      rdc(8'h04, 32'h96);
      rdc(8'h08, 32'h0b);
      give_verdict();
   end
endmodule // serial_channel_control_status_test
